/* rtl/radio_spi_slave.sv */
`timescale 1ns/10ps
`default_nettype none
module radio_spi_slave
    import radio_spi_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial link
    radio_spi_if.dev spi,
    // Chip condition
    input wire logic supply_ok,
    input wire logic xtal_ok,
    input wire logic [2:0] chip_state,
    input wire logic [3:0] fifo_free,
    // Register side
    output logic reg_wr_q,
    output logic reg_rd_q,
    output logic [5:0] reg_addr_q,
    output logic [7:0] reg_wdata_q,
    input wire logic [7:0] reg_rdata,
    output logic fifo_wr_q,
    output logic [7:0] fifo_wdata_q,
    output logic strobe_q,
    output logic [5:0] strobe_addr_q,
    output logic power_down_strobe_q,
    output logic osc_stop_strobe_q
);
    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [1:0] sclk_s_q, sel_s_q, mosi_s_q;
    logic sclk_d1_q;
    always_ff @(posedge clk) begin
        sclk_s_q <= {sclk_s_q[0], spi.sclk};
        sel_s_q <= {sel_s_q[0], spi.select_low};
        mosi_s_q <= {mosi_s_q[0], spi.mosi};
        sclk_d1_q <= sclk_s_q[1];
    end
    logic sclk_rise, sclk_fall, sel_n, ready;
    assign sclk_rise = sclk_s_q[1] & ~sclk_d1_q;
    assign sclk_fall = ~sclk_s_q[1] & sclk_d1_q;
    assign sel_n = sel_s_q[1];
    assign ready = supply_ok & xtal_ok;
    // ****************************************************************
    // Framing state
    // ****************************************************************
    logic [2:0] bit_q;
    logic [7:0] sh_q, tx_q;
    logic hdr_q, rw_q, burst_q, done_q, miso_q;
    logic [5:0] addr_q;
    logic pend_pwd_q, pend_crystal_off_state_q;
    logic [7:0] rx_byte;
    logic [7:0] status;
    assign rx_byte = {sh_q[6:0], mosi_s_q[1]};
    assign status = {~ready, chip_state, fifo_free};
    // Bit counter and shifter on rising sclk; select high clears all
    always_ff @(posedge clk) begin
        if (rst || sel_n) begin
            bit_q <= 3'd0;
            sh_q <= 8'h00;
            hdr_q <= 1'b1;
            rw_q <= 1'b0;
            burst_q <= 1'b0;
            addr_q <= 6'h00;
            done_q <= 1'b0;
        end else if (sclk_rise && ready) begin
            // Marks the cycle after a byte completes, for the read fetch
            done_q <= (bit_q == 3'd7);
            sh_q <= rx_byte;
            bit_q <= bit_q + 3'd1;
            if (bit_q == 3'd7) begin
                if (hdr_q) begin
                    rw_q <= rx_byte[rw_bit];
                    burst_q <= rx_byte[burst_bit];
                    addr_q <= rx_byte[addr_msb:0];
                    // Strobes carry no data: next byte is a new header
                    hdr_q <= (rx_byte[addr_msb:0] >= strobe_lo) &&
                        (rx_byte[addr_msb:0] <= strobe_hi) && !rx_byte[rw_bit];
                end else begin
                    // Single access returns to header; burst keeps data
                    hdr_q <= ~burst_q;
                    if (burst_q && addr_q != fifo_addr) begin
                        addr_q <= addr_q + 6'd1;
                    end
                end
            end
        end else begin
            done_q <= 1'b0;
        end
    end
    // Completed-byte actions, one-cycle pulses
    always_ff @(posedge clk) begin
        reg_wr_q <= 1'b0;
        reg_rd_q <= 1'b0;
        fifo_wr_q <= 1'b0;
        strobe_q <= 1'b0;
        if (rst) begin
            reg_addr_q <= 6'h00;
            reg_wdata_q <= 8'h00;
            fifo_wdata_q <= 8'h00;
            strobe_addr_q <= 6'h00;
        end else if (!sel_n && sclk_rise && ready && bit_q == 3'd7) begin
            if (hdr_q) begin
                // Strobes other than the deferred two act now
                if (rx_byte[addr_msb:0] >= strobe_lo && rx_byte[addr_msb:0] <= strobe_hi
                    && !rx_byte[rw_bit] && !rx_byte[burst_bit]
                    && rx_byte[addr_msb:0] != pwd_strobe_addr
                    && rx_byte[addr_msb:0] != crystal_off_state_strobe_addr) begin
                    strobe_q <= 1'b1;
                    strobe_addr_q <= rx_byte[addr_msb:0];
                end
            end else if (addr_q == fifo_addr && !rw_q) begin
                fifo_wr_q <= 1'b1;
                fifo_wdata_q <= rx_byte;
            end else if (!rw_q) begin
                reg_wr_q <= 1'b1;
                reg_addr_q <= addr_q;
                reg_wdata_q <= rx_byte;
            end
        end else if (!sel_n && done_q && !hdr_q && rw_q) begin
            // Fetch read data right after the previous byte, well before its MSB is shown
            reg_rd_q <= 1'b1;
            reg_addr_q <= addr_q;
        end
    end
    // Deferred power-down and osc-stop strobes fire when select rises
    always_ff @(posedge clk) begin
        power_down_strobe_q <= 1'b0;
        osc_stop_strobe_q <= 1'b0;
        if (rst) begin
            pend_pwd_q <= 1'b0;
            pend_crystal_off_state_q <= 1'b0;
        end else if (sel_n) begin
            power_down_strobe_q <= pend_pwd_q;
            osc_stop_strobe_q <= pend_crystal_off_state_q;
            pend_pwd_q <= 1'b0;
            pend_crystal_off_state_q <= 1'b0;
        end else if (sclk_rise && ready && bit_q == 3'd7 && hdr_q
            && !rx_byte[rw_bit] && !rx_byte[burst_bit]) begin
            if (rx_byte[addr_msb:0] == pwd_strobe_addr) pend_pwd_q <= 1'b1;
            if (rx_byte[addr_msb:0] == crystal_off_state_strobe_addr) pend_crystal_off_state_q <= 1'b1;
        end
    end
    // Output shifter: status while header or write data, read data otherwise
    always_ff @(posedge clk) begin
        if (rst || sel_n) begin
            tx_q <= reset_status;
            miso_q <= 1'b1;
        end else if (!ready) begin
            miso_q <= 1'b1;
        end else if (bit_q == 3'd0 && !sclk_rise && !sclk_s_q[1]) begin
            // Between bytes with sclk low: load next byte, present its MSB
            tx_q <= (!hdr_q && rw_q) ? reg_rdata : status;
            miso_q <= (!hdr_q && rw_q) ? reg_rdata[7] : status[st_rdy_bit];
        end else if (sclk_fall) begin
            tx_q <= {tx_q[6:0], 1'b0};
            miso_q <= tx_q[6];
        end
    end
    assign spi.miso = miso_q;
endmodule : radio_spi_slave
`default_nettype wire

/* rtl/radio_spi_pkg.sv */
package radio_spi_pkg;
    // ****************************************************************
    // Header byte layout
    // ****************************************************************
    localparam int unsigned rw_bit = 7;
    localparam int unsigned burst_bit = 6;
    localparam int unsigned addr_msb = 5;
    localparam int unsigned addr_w = 6;
    localparam int unsigned byte_w = 8;
    localparam logic [5:0] fifo_addr = 6'h3F;
    localparam logic [5:0] strobe_lo = 6'h30;
    localparam logic [5:0] strobe_hi = 6'h3D;
    localparam logic [5:0] pwd_strobe_addr = 6'h39;
    localparam logic [5:0] crystal_off_state_strobe_addr = 6'h32;
    // ****************************************************************
    // Status byte layout
    // ****************************************************************
    localparam int unsigned st_rdy_bit = 7;
    localparam int unsigned st_state_lsb = 4;
    localparam int unsigned st_free_lsb = 0;
    // ****************************************************************
    // Timing counts and reset status byte
    // ****************************************************************
    localparam int unsigned sclk_half_ns = 50;
    localparam int unsigned clk_ns = 10;
    localparam int unsigned sclk_half_cyc = (sclk_half_ns + clk_ns - 1) / clk_ns;
    localparam logic [7:0] reset_status = 8'h00;
endpackage : radio_spi_pkg

/* rtl/radio_spi_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface radio_spi_if;
    // Host driven
    logic sclk;
    logic select_low;
    logic mosi;
    // Device driven
    logic miso;
    modport dev (input sclk, input select_low, input mosi, output miso);
    modport host (output sclk, output select_low, output mosi, input miso);
endinterface : radio_spi_if
`default_nettype wire

/* rtl/radio_spi_master.sv */
`timescale 1ns/10ps
`default_nettype none
module radio_spi_master
    import radio_spi_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Command port: 0 transmit byte, 4 received byte, 8 control/status
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata_q,
    // Serial link
    radio_spi_if.host spi
);
    // ****************************************************************
    // Command registers
    // ****************************************************************
    localparam logic [3:0] a_tx = 4'h0;
    localparam logic [3:0] a_rx = 4'h4;
    localparam logic [3:0] a_ctl = 4'h8;
    typedef enum logic [1:0] {idle_type = 2'b00, wait_rdy_type = 2'b01,
        shift_type = 2'b11} st_type;
    st_type st_q;
    logic [7:0] out_q, in_q, last_q;
    logic [2:0] bit_q;
    logic [3:0] div_q;
    logic sclk_q, sel_q, mosi_q, go_q;
    logic rdy_seen_q;
    logic [1:0] miso_s_q;
    always_ff @(posedge clk) miso_s_q <= {miso_s_q[0], spi.miso};
    // Readback: last received byte, busy and select flags
    always_ff @(posedge clk) begin
        if (rst) rdata_q <= 8'h00;
        else if (rd) begin
            unique case (addr)
                a_rx: rdata_q <= last_q;
                a_ctl: rdata_q <= {6'h00, st_q != idle_type, ~sel_q};
                default: rdata_q <= 8'h00;
            endcase
        end
    end
    // Byte engine: ctl bit0 holds select low, writes to tx send a byte
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= idle_type;
            sel_q <= 1'b1;
            sclk_q <= 1'b0;
            mosi_q <= 1'b0;
            out_q <= 8'h00;
            in_q <= 8'h00;
            last_q <= 8'h00;
            bit_q <= 3'd0;
            div_q <= 4'd0;
            go_q <= 1'b0;
            rdy_seen_q <= 1'b0;
        end else begin
            // Ready is only signalled once per select; later bytes may start with a high MSB
            if (sel_q) rdy_seen_q <= 1'b0;
            if (wr && addr == a_ctl) sel_q <= ~wdata[0];
            if (wr && addr == a_tx) begin
                out_q <= wdata;
                go_q <= 1'b1;
            end
            unique case (st_q)
                idle_type: if (go_q && !sel_q) begin
                    go_q <= 1'b0;
                    st_q <= wait_rdy_type;
                end
                wait_rdy_type: if (sel_q) begin
                    st_q <= idle_type;
                end else if (!miso_s_q[1] || rdy_seen_q) begin
                    rdy_seen_q <= 1'b1;
                    st_q <= shift_type;
                    mosi_q <= out_q[7];
                    bit_q <= 3'd0;
                    div_q <= 4'd0;
                end
                shift_type: if (sel_q) begin
                    // Abort: park the clock low so no rising edge follows a released select
                    st_q <= idle_type;
                    sclk_q <= 1'b0;
                end else begin
                    div_q <= div_q + 4'd1;
                    if (div_q == 4'(sclk_half_cyc + 2)) begin
                        div_q <= 4'd0;
                        sclk_q <= ~sclk_q;
                        if (!sclk_q) begin
                            in_q <= {in_q[6:0], miso_s_q[1]};
                        end else begin
                            out_q <= {out_q[6:0], 1'b0};
                            mosi_q <= out_q[6];
                            bit_q <= bit_q + 3'd1;
                            if (bit_q == 3'd7) begin
                                last_q <= in_q;
                                st_q <= idle_type;
                            end
                        end
                    end
                end
                default: st_q <= idle_type;
            endcase
        end
    end
    assign spi.sclk = sclk_q;
    assign spi.select_low = sel_q;
    assign spi.mosi = mosi_q;
endmodule : radio_spi_master
`default_nettype wire

/* dv/radio_spi_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module radio_spi_chk
    import radio_spi_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial link
    input wire logic sclk,
    input wire logic select_low,
    input wire logic mosi,
    input wire logic miso
);
    // ****
    // Link checks
    // ****
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic first_q;
    // Armed while deselected, cleared once the clock goes high
    always_ff @(posedge clk) begin
        if (rst || select_low) begin
            first_q <= 1'b1;
        end else if (sclk) begin
            first_q <= 1'b0;
        end
    end
    // Six cycles covers the slave's select synchroniser
    sequence s_idle; select_low [*6]; endsequence
    sequence s_high; sclk [*5]; endsequence
    sequence s_low; !sclk [*5]; endsequence
    idle_miso_a: assert property (s_idle |-> miso) else $error("miso not idle");
    idle_clk_a: assert property (s_idle |-> !sclk) else $error("clock while idle");
    sel_clk_a: assert property ($rose(sclk) |-> !select_low) else $error("clock unselected");
    first_bit_a: assert property ($rose(sclk) && first_q |-> !miso) else $error("not ready");
    // An abort may cut the high phase short
    clk_high_a: assert property ($rose(sclk) |-> s_high or ##[1:4] select_low)
        else $error("short high");
    clk_low_a: assert property ($fell(sclk) |-> s_low) else $error("short low");
    mosi_hold_a: assert property (sclk && $past(sclk) |-> $stable(mosi)) else $error("mosi moved");
    miso_hold_a: assert property (!select_low && sclk && $past(sclk) |-> $stable(miso))
        else $error("miso moved");
endmodule : radio_spi_chk
`default_nettype wire

/* dv/test_radio_spi_slave_framing.sv */
`timescale 1ns/10ps
`default_nettype none
module test_radio_spi_slave_framing
    import radio_spi_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, supply_ok = 1'b0, xtal_ok = 1'b0;
    logic [3:0] addr = 4'h0, fifo_free = 4'h9;
    logic [2:0] chip_state = 3'h2;
    logic [7:0] wdata = 8'h00, reg_rdata = 8'h00, rdata_q, st, reg_wdata_q, fifo_wdata_q, fq[$];
    logic [5:0] reg_addr_q, strobe_addr_q, sq[$];
    logic reg_wr_q, reg_rd_q, fifo_wr_q, strobe_q, power_down_strobe_q, osc_stop_strobe_q;
    logic [13:0] wq[$];
    int err_total = 0, cmp_count = 0, pd_n = 0, osc_n = 0;
    always #5 clk = ~clk;
    radio_spi_if bus ();
    radio_spi_master radio_spi_master_i (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata_q, .spi(bus));
    radio_spi_slave radio_spi_slave_i (.clk, .rst, .spi(bus), .supply_ok, .xtal_ok, .chip_state,
        .fifo_free, .reg_wr_q, .reg_rd_q, .reg_addr_q, .reg_wdata_q, .reg_rdata, .fifo_wr_q,
        .fifo_wdata_q, .strobe_q, .strobe_addr_q, .power_down_strobe_q, .osc_stop_strobe_q);
    radio_spi_chk radio_spi_chk_i (.clk, .rst, .sclk(bus.sclk), .select_low(bus.select_low),
        .mosi(bus.mosi), .miso(bus.miso));
    // Pulses last one cycle, so log all but reg_rd_q and compare later
    always @(posedge clk) begin
        if (reg_wr_q) wq.push_back({reg_addr_q, reg_wdata_q});
        if (fifo_wr_q) fq.push_back(fifo_wdata_q);
        if (strobe_q) sq.push_back(strobe_addr_q);
        if (power_down_strobe_q) pd_n++;
        if (osc_stop_strobe_q) osc_n++;
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // One command port cycle; read data lands in st
    task acc(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        {wr, rd} <= {w, !w};
        @(posedge clk);
        {wr, rd} <= 2'b00;
        #1 st = rdata_q;
    endtask : acc
    // Busy needs a few cycles to rise, so early polls are ignored
    task xfer(input logic [7:0] b);
        acc(1'b1, 4'h0, b);
        for (int i = 0; i < 300; i++) begin
            acc(1'b0, 4'h8, 8'h00);
            if (!st[1] && i > 2) break;
        end
        acc(1'b0, 4'h4, 8'h00);
    endtask : xfer
    task sel(input logic on);
        acc(1'b1, 4'h8, {7'h00, on});
        repeat (30) @(posedge clk);
    endtask : sel
    task frame(input logic [7:0] b[$]);
        sel(1'b1);
        foreach (b[i]) xfer(b[i]);
        sel(1'b0);
    endtask : frame
    task report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop
    // Watchdog well above the expected run length
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        report_and_stop();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        // Data-out stays high until supply and crystal are both good
        sel(1'b1);
        chk(bus.miso, 1'b1);
        {supply_ok, xtal_ok} <= 2'b10;
        repeat (10) @(posedge clk);
        chk(bus.miso, 1'b1);
        xtal_ok <= 1'b1;
        repeat (10) @(posedge clk);
        chk(bus.miso, 1'b0);
        $display("test ready done");
        // Single write and FIFO writes, a burst, then a read
        frame('{8'h05, 8'hA5, 8'h3F, 8'h11, 8'h7F, 8'h22, 8'h33});
        chk(st, 8'h29);
        chk(wq[0], 14'h05A5);
        chk(fq.size(), 16'h0003);
        chk(fq[2], 8'h33);
        frame('{8'h50, 8'hC0, 8'hC1, 8'hC2});
        chk(wq.size(), 16'h0004);
        chk(wq[3], 14'h12C2);
        reg_rdata <= 8'h3C;
        frame('{8'h8A, 8'h00});
        chk(st, 8'h3C);
        $display("test transfer done");
        // Strobes: one at once, the other two held until select rises
        sel(1'b1);
        xfer(8'h30);
        chk(sq[0], 6'h30);
        xfer(8'h39);
        xfer(8'h32);
        chk(pd_n + osc_n, 0);
        sel(1'b0);
        chk({pd_n[7:0], osc_n[7:0]}, 16'h0101);
        // Select released mid byte drops the write; the next one lands
        sel(1'b1);
        xfer(8'h07);
        acc(1'b1, 4'h0, 8'h5A);
        repeat (60) @(posedge clk);
        sel(1'b0);
        repeat (200) @(posedge clk);
        frame('{8'h07, 8'h66});
        chk(wq.size(), 16'h0005);
        chk(wq[4], 14'h0766);
        $display("test strobe abort done");
        report_and_stop();
    end
endmodule : test_radio_spi_slave_framing
`default_nettype wire
